// >>> logic/lfo_pkg.sv
// Purpose: constants and types for the low-frequency oscillator control
// Assumes: 8-bit special function register port, one 250 MHz clock
// Notes: oscillator outputs arrive as asynchronous pins
package lfo_pkg;
    localparam logic [7:0] LFO_CTRL_ADDR = 8'he3;
    localparam int LFO_EN_BIT = 7;
    localparam int LFO_RDY_BIT = 6;
    localparam int LFO_TRIM_LSB = 2;
    localparam int LFO_DIV_LSB = 0;
    localparam logic [3:0] LFO_TRIM_RST = 4'h8;
    localparam logic [1:0] LFO_DIV_RST = 2'h0;
    // settle time in raw oscillator edges before ready is set
    localparam logic [3:0] LFO_SETTLE_EDGES = 4'h8;
    // external oscillator mode codes
    localparam logic [2:0] LFO_XMODE_CMOS = 3'h2;
    localparam logic [2:0] LFO_XMODE_CMOS_D2 = 3'h3;
    localparam logic [2:0] LFO_XMODE_RC = 3'h4;
    localparam logic [2:0] LFO_XMODE_CAP = 3'h5;
    localparam logic [2:0] LFO_XMODE_XTAL = 3'h6;
    localparam logic [2:0] LFO_XMODE_XTAL_D2 = 3'h7;
    localparam logic [1:0] LFO_SYSCLK_LOWPWR = 2'h2;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
    } lfo_sfr_req_t;

    typedef struct packed {
        logic cap_en;
        logic [15:0] count;
    } lfo_tmr_t;

    typedef struct packed {
        logic p02_claim;
        logic p03_claim;
    } lfo_pins_t;
endpackage : lfo_pkg

// >>> logic/lfo_capture.sv
// Purpose: one timer's capture of its count on an oscillator edge
// Assumes: edge pulse comes from the same clock domain
// Notes: instantiated once per timer
`timescale 1ns/1ps
`default_nettype none
module lfo_capture
(
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    // timer side
    input wire lfo_pkg::lfo_tmr_t tmr_i,
    input wire logic edge_i,
    output logic [15:0] reload_o,
    output logic captured_o
);
    import lfo_pkg::*;

    typedef struct packed {
        logic [15:0] reload;
        logic captured;
    } lfo_cap_state_t;

    lfo_cap_state_t state_r;
    lfo_cap_state_t state_nxt;

    always_comb
    begin
        state_nxt = state_r;
        state_nxt.captured = 1'b0;
        if (tmr_i.cap_en && edge_i)
        begin
            // high and low bytes copied together
            state_nxt.reload = tmr_i.count;
            state_nxt.captured = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            state_r <= '0;
        else
            state_r <= state_nxt;
    end

    assign reload_o = state_r.reload;
    assign captured_o = state_r.captured;

    AST_CAP_COPY: assert property (@(posedge sys_clk_i)
        disable iff (!reset_n_i)
        (tmr_i.cap_en && edge_i) |=> (reload_o == $past(tmr_i.count))
            && captured_o)
        else $error("capture did not copy count");
endmodule // lfo_capture
`default_nettype wire

// >>> logic/lfo_ctrl.sv
// Purpose: low-frequency oscillator control register and capture paths
// Assumes: analogue oscillator cells sit outside; their outputs are async
// Notes: ready counts raw oscillator edges after enable
`timescale 1ns/1ps
`default_nettype none
module lfo_ctrl
(
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    // special function register port
    input wire lfo_pkg::lfo_sfr_req_t sfr_i,
    output logic [7:0] sfr_rdata_o,
    // factory trim loaded after reset
    input wire logic [3:0] factory_trim_i,
    // analogue oscillator cell
    output logic lf_osc_enable_o,
    output logic [3:0] lf_freq_trim_o,
    input wire logic lf_osc_raw_i,
    output logic lf_osc_clk_o,
    // timers 2 and 3
    input wire lfo_pkg::lfo_tmr_t tmr2_i,
    input wire lfo_pkg::lfo_tmr_t tmr3_i,
    output logic [15:0] tmr2_reload_o,
    output logic [15:0] tmr3_reload_o,
    output logic tmr2_captured_o,
    output logic tmr3_captured_o,
    // low-power oscillator and external oscillator pins
    input wire logic [1:0] sysclk_sel_i,
    output logic lowpwr_osc_en_o,
    input wire logic [2:0] ext_osc_mode_i,
    output var lfo_pkg::lfo_pins_t pins_o
);
    import lfo_pkg::*;

    typedef struct packed {
        logic [2:0] raw_sync;
        logic trim_loaded;
        logic enable;
        logic ready;
        logic [3:0] trim;
        logic [1:0] div;
        logic [3:0] settle;
        logic [2:0] div_cnt;
        logic div_clk;
        logic div_prev;
    } lfo_state_t;

    lfo_state_t state_r;
    lfo_state_t state_nxt;
    logic ctrl_wr;
    logic raw_rise;
    logic div_tick;
    logic [2:0] div_limit;
    logic [7:0] ctrl_wdata;

    assign ctrl_wr = sfr_i.wr && (sfr_i.addr == LFO_CTRL_ADDR);
    assign ctrl_wdata = sfr_i.wdata;
    // stage 0 feeds stage 1 only; edges are seen between stages 1 and 2
    assign raw_rise = state_r.raw_sync[1] && !state_r.raw_sync[2];

    always_comb
    begin
        unique case (state_r.div)
            2'h0: div_limit = 3'h7;
            2'h1: div_limit = 3'h3;
            2'h2: div_limit = 3'h1;
            2'h3: div_limit = 3'h0;
        endcase
    end

    // one tick per divided output half period
    assign div_tick = raw_rise && (state_r.div_cnt >= div_limit);

    always_comb
    begin
        state_nxt = state_r;
        state_nxt.raw_sync = {state_r.raw_sync[1:0], lf_osc_raw_i};
        // strap-like load of factory trim after reset release
        if (!state_r.trim_loaded)
        begin
            state_nxt.trim = factory_trim_i;
            state_nxt.trim_loaded = 1'b1;
        end
        if (!state_r.enable)
        begin
            state_nxt.settle = '0;
            state_nxt.div_cnt = '0;
        end
        else if (raw_rise)
        begin
            state_nxt.div_cnt = div_tick ? 3'h0 : state_r.div_cnt + 3'h1;
            if (div_tick)
                state_nxt.div_clk = !state_r.div_clk;
            if (state_r.settle != LFO_SETTLE_EDGES)
                state_nxt.settle = state_r.settle + 4'h1;
            else
                state_nxt.ready = 1'b1;
        end
        if (ctrl_wr)
        begin
            state_nxt.enable = ctrl_wdata[LFO_EN_BIT];
            // trim passes straight to the cell; changing it live is a
            // software hazard, not blocked here
            state_nxt.trim = ctrl_wdata[LFO_TRIM_LSB +: 4];
            state_nxt.trim_loaded = 1'b1;
            state_nxt.div = ctrl_wdata[LFO_DIV_LSB +: 2];
            if (ctrl_wdata[LFO_DIV_LSB +: 2] != state_r.div)
            begin
                // divider change restarts the settle wait
                state_nxt.ready = 1'b0;
                state_nxt.settle = '0;
                state_nxt.div_cnt = '0;
            end
        end
        state_nxt.div_prev = state_r.div_clk;
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            state_r <= '0;
            state_r.trim <= LFO_TRIM_RST;
            state_r.div <= LFO_DIV_RST;
        end
        else
            state_r <= state_nxt;
    end

    assign sfr_rdata_o = (sfr_i.addr == LFO_CTRL_ADDR) ?
        {state_r.enable, state_r.ready, state_r.trim, state_r.div} : 8'h00;
    assign lf_osc_enable_o = state_r.enable;
    assign lf_freq_trim_o = state_r.trim;
    assign lf_osc_clk_o = state_r.div_clk;

    logic div_fall;
    logic div_rise;
    assign div_rise = state_r.div_clk && !state_r.div_prev;
    assign div_fall = !state_r.div_clk && state_r.div_prev;

    lfo_capture u_cap2
    (
        .sys_clk_i(sys_clk_i),
        .reset_n_i(reset_n_i),
        .tmr_i(tmr2_i),
        .edge_i(div_fall),
        .reload_o(tmr2_reload_o),
        .captured_o(tmr2_captured_o)
    );

    lfo_capture u_cap3
    (
        .sys_clk_i(sys_clk_i),
        .reset_n_i(reset_n_i),
        .tmr_i(tmr3_i),
        .edge_i(div_rise),
        .reload_o(tmr3_reload_o),
        .captured_o(tmr3_captured_o)
    );

    assign lowpwr_osc_en_o = (sysclk_sel_i == LFO_SYSCLK_LOWPWR);

    always_comb
    begin
        pins_o = '0;
        unique case (ext_osc_mode_i)
            LFO_XMODE_XTAL, LFO_XMODE_XTAL_D2:
            begin
                pins_o.p02_claim = 1'b1;
                pins_o.p03_claim = 1'b1;
            end
            LFO_XMODE_CMOS, LFO_XMODE_CMOS_D2, LFO_XMODE_RC, LFO_XMODE_CAP:
                pins_o.p03_claim = 1'b1;
            default:
                pins_o = '0;
        endcase
    end

    AST_DIV_CHANGE_CLEARS: assert property (@(posedge sys_clk_i)
        disable iff (!reset_n_i)
        (ctrl_wr && ctrl_wdata[1:0] != state_r.div) |=> !state_r.ready)
        else $error("ready survived divider change");
    AST_READY_HOLDS: assert property (@(posedge sys_clk_i)
        disable iff (!reset_n_i)
        (state_r.ready && !(ctrl_wr && ctrl_wdata[1:0] != state_r.div))
            |=> state_r.ready)
        else $error("ready fell without cause");
    AST_ENABLE_WRITE: assert property (@(posedge sys_clk_i)
        disable iff (!reset_n_i)
        ctrl_wr |=> lf_osc_enable_o == $past(ctrl_wdata[7]))
        else $error("enable not taken from write");
    AST_TRIM_WRITE: assert property (@(posedge sys_clk_i)
        disable iff (!reset_n_i)
        ctrl_wr |=> lf_freq_trim_o == $past(ctrl_wdata[5:2]))
        else $error("trim not taken from write");
    AST_NO_READY_OFF: assert property (@(posedge sys_clk_i)
        disable iff (!reset_n_i)
        (!state_r.enable && !state_r.ready) |=> !state_r.ready)
        else $error("ready set while disabled");
    AST_DIV1_TOGGLE: assert property (@(posedge sys_clk_i)
        disable iff (!reset_n_i)
        (state_r.enable && state_r.div == 2'h3 && raw_rise && !ctrl_wr)
            |=> lf_osc_clk_o != $past(lf_osc_clk_o))
        else $error("divide by 1 missed an edge");
    AST_LOWPWR: assert property (@(posedge sys_clk_i)
        disable iff (!reset_n_i)
        lowpwr_osc_en_o == (sysclk_sel_i == LFO_SYSCLK_LOWPWR))
        else $error("low-power enable wrong");
    AST_XTAL_PINS: assert property (@(posedge sys_clk_i)
        disable iff (!reset_n_i)
        (ext_osc_mode_i[2:1] == 2'h3) |-> pins_o.p02_claim && pins_o.p03_claim)
        else $error("crystal pins not claimed");
    AST_OTHER_PINS: assert property (@(posedge sys_clk_i)
        disable iff (!reset_n_i)
        (ext_osc_mode_i inside {3'h2, 3'h3, 3'h4, 3'h5})
            |-> !pins_o.p02_claim && pins_o.p03_claim)
        else $error("wrong pin claim");
endmodule // lfo_ctrl
`default_nettype wire

// >>> verification/lfo_osc_model.sv
// Purpose: far-side model, oscillator cell plus timer 2 and 3 counters
// Assumes: raw output parks low while the cell is disabled
// Notes: half period is no multiple of the system clock on purpose
`timescale 1ns/1ps
`default_nettype none
module lfo_osc_model
#(
    parameter int HALF_NS = 14,
    parameter logic [15:0] CNT_START = 16'hfff0
)
(
    // clock
    input wire logic sys_clk_i,
    // oscillator cell
    input wire logic lf_osc_enable_i,
    output logic raw_o,
    // timer counts
    output logic [15:0] tmr2_count_o,
    output logic [15:0] tmr3_count_o
);
    initial raw_o = 1'b0;
    initial tmr2_count_o = CNT_START;
    initial tmr3_count_o = ~CNT_START;
    // a stopped cell gives no edges, so no stale toggling reaches the dut
    always
    begin
        if (lf_osc_enable_i === 1'b1)
        begin
            #(HALF_NS);
            raw_o = ~raw_o;
        end
        else
        begin
            raw_o = 1'b0;
            @(lf_osc_enable_i);
        end
    end
    // timer 2 starts at CNT_START near wrap, timer 3 at its inverse; both step once per system clock
    always @(posedge sys_clk_i)
    begin
        tmr2_count_o <= tmr2_count_o + 16'h1;
        tmr3_count_o <= tmr3_count_o + 16'h1;
    end
endmodule // lfo_osc_model
`default_nettype wire

// >>> verification/tb.sv
// Purpose: self-checking bench for the low-frequency oscillator control
// Assumes: model drives raw oscillator and timer counts
// Notes: divide ratio measured as raw rises per output half period
`timescale 1ns/1ps
`default_nettype none
module tb;
    import lfo_pkg::*;
    logic sys_clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    // address parked on the control register so reset reads show it
    lfo_sfr_req_t sfr_i = '{LFO_CTRL_ADDR, 8'h00, 1'b0};
    logic [3:0] ftrim = 4'h0;
    logic cap_en = 1'b0;
    logic [1:0] sel = 2'h0;
    logic [2:0] xmode = 3'h0;
    logic [7:0] rdata;
    logic [3:0] trim_o;
    logic en, raw, div_clk, cap2, cap3, lp_en;
    logic [15:0] cnt2, cnt3, rl2, rl3;
    lfo_pins_t pins;
    int bad_count = 0;
    int comparisons = 0;
    int rises = 0;
    int n2 = 0;
    int n3 = 0;
    int m_en, m_trim, m_div, i, d;
    int gaps[$];

    always #2 sys_clk_i = ~sys_clk_i;

    lfo_osc_model i_osc (.sys_clk_i(sys_clk_i), .lf_osc_enable_i(en),
        .raw_o(raw), .tmr2_count_o(cnt2), .tmr3_count_o(cnt3));
    lfo_ctrl i_dut (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
        .sfr_i(sfr_i), .sfr_rdata_o(rdata), .factory_trim_i(ftrim),
        .lf_osc_enable_o(en), .lf_freq_trim_o(trim_o), .lf_osc_raw_i(raw),
        .lf_osc_clk_o(div_clk), .tmr2_i({cap_en, cnt2}),
        .tmr3_i({cap_en, cnt3}), .tmr2_reload_o(rl2), .tmr3_reload_o(rl3),
        .tmr2_captured_o(cap2), .tmr3_captured_o(cap3),
        .sysclk_sel_i(sel), .lowpwr_osc_en_o(lp_en),
        .ext_osc_mode_i(xmode), .pins_o(pins));

    task automatic final_report();
        if (bad_count == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            bad_count++;
        end
    endtask

    // a bound that runs out is a mismatch and ends the run
    task automatic tmo(input int lim);
        if (i >= lim)
        begin
            $display("MISMATCH t=%0t got=%h exp=%h", $time, i, lim);
            bad_count++;
            final_report();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge sys_clk_i);
        sfr_i <= '{a, v, 1'b1};
        @(posedge sys_clk_i);
        sfr_i.wr <= 1'b0;
        #1;
    endtask

    // ready is left out here, it is checked on its own
    task automatic chk_reg();
        chk(16'({rdata[7], rdata[5:0]}),
            16'(m_en * 64 + m_trim * 4 + m_div));
    endtask

    task automatic wr_model();
        wr(LFO_CTRL_ADDR, 8'(m_en * 128 + m_trim * 4 + m_div));
    endtask

    always @(posedge raw) rises++;
    always @(div_clk)
    begin
        gaps.push_back(rises);
        rises = 0;
    end

    // sampled mid-cycle, after the capturing edge has settled
    always @(negedge sys_clk_i)
    begin
        if (cap2 === 1'b1)
        begin
            n2++;
            chk(rl2, cnt2 - 16'h1);
            chk(16'(div_clk), 16'h0);
        end
        if (cap3 === 1'b1)
        begin
            n3++;
            chk(rl3, cnt3 - 16'h1);
            chk(16'(div_clk), 16'h1);
        end
    end

    initial
    begin
        repeat (60000) @(posedge sys_clk_i);
        bad_count++;
        final_report();
    end

    initial
    begin
        void'($urandom(32'hb6f3));
        ftrim <= 4'($urandom);
        repeat (5) @(posedge sys_clk_i);
        chk(16'(rdata), 16'h20);
        reset_n_i <= 1'b1;
        repeat (2) @(posedge sys_clk_i);
        #1;
        m_en = 0;
        m_trim = ftrim;
        m_div = 0;
        chk_reg();
        chk(16'(rdata[6]), 16'h0);
        // trim changed only with the oscillator stopped
        m_trim = $urandom_range(15);
        m_div = 3;
        wr(LFO_CTRL_ADDR, 8'(m_trim * 4 + m_div) | 8'h40);
        chk_reg();
        chk(16'(rdata[6]), 16'h0);
        chk(16'(trim_o), 16'(m_trim));
        chk(16'(en), 16'h0);
        m_en = 1;
        wr_model();
        chk(16'(en), 16'h1);
        for (i = 0; i < 1000 && rdata[6] !== 1'b1; i++)
            @(posedge sys_clk_i);
        tmo(1000);
        chk(16'(rdata[6]), 16'h1);
        wr_model();
        chk(16'(rdata[6]), 16'h1);
        wr(8'h00, 8'hff);
        chk(16'(rdata), 16'h0);
        for (d = 0; d < 4; d++)
        begin
            m_div = d;
            wr_model();
            chk_reg();
            chk(16'(rdata[6]), 16'h0);
            gaps.delete();
            for (i = 0; i < 3000 && gaps.size() < 3; i++)
                @(posedge sys_clk_i);
            tmo(3000);
            chk(16'(gaps[2]), 16'(8 >> d));
        end
        @(posedge sys_clk_i);
        cap_en <= 1'b1;
        for (i = 0; i < 3000 && (n2 < 3 || n3 < 3); i++)
            @(posedge sys_clk_i);
        cap_en <= 1'b0;
        tmo(3000);
        chk(16'(n2 >= 3 && n3 >= 3), 16'h1);
        // capture mode off: no further captures may arrive
        @(posedge sys_clk_i);
        d = n2 + n3;
        repeat (30) @(posedge sys_clk_i);
        chk(16'(n2 + n3), 16'(d));
        for (i = 0; i < 4; i++)
        begin
            @(posedge sys_clk_i);
            sel <= 2'(i);
            #1;
            chk(16'(lp_en), 16'(i == 2));
        end
        for (i = 0; i < 8; i++)
        begin
            @(posedge sys_clk_i);
            xmode <= 3'(i);
            #1;
            chk(16'(pins), 16'({i >= 6, i >= 2}));
        end
        for (i = 0; i < 1000 && rdata[6] !== 1'b1; i++)
            @(posedge sys_clk_i);
        tmo(1000);
        m_en = 0;
        wr_model();
        chk(16'(en), 16'h0);
        chk(16'(rdata[6]), 16'h1);
        @(posedge sys_clk_i);
        reset_n_i <= 1'b0;
        #1;
        chk(16'(rdata), 16'h20);
        @(posedge sys_clk_i);
        ftrim <= 4'($urandom);
        @(posedge sys_clk_i);
        reset_n_i <= 1'b1;
        repeat (2) @(posedge sys_clk_i);
        #1;
        m_trim = ftrim;
        m_div = 0;
        chk_reg();
        chk(16'(rdata[6]), 16'h0);
        final_report();
    end
endmodule // tb
`default_nettype wire
